// file: core/snerf_pkg.sv
// Purpose: Shared constants and types for the serial NAND command core
// Assumes: Opcodes and feature addresses as seen on the SPI link
// Notes:   Times in ns, cycle counts derived from the 20 MHz clock
package snerf_pkg;

   localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_ERASE      = 8'hd8;
   localparam logic [7:0] OP_SOFT_RST   = 8'hff;
   localparam logic [7:0] OP_EN_POR     = 8'h66;
   localparam logic [7:0] OP_POR        = 8'h99;
   localparam logic [7:0] OP_GET_FEAT   = 8'h0f;
   localparam logic [7:0] OP_SET_FEAT   = 8'h1f;
   localparam logic [7:0] OP_READ_X4    = 8'h6b;
   localparam logic [7:0] OP_LOAD_X4    = 8'h32;

   localparam logic [7:0] FA_PROTECT    = 8'ha0;
   localparam logic [7:0] FA_CONFIG     = 8'hb0;
   localparam logic [7:0] FA_STATUS     = 8'hc0;
   localparam logic [7:0] FA_DRIVE      = 8'hd0;
   localparam logic [7:0] FA_EXT_STATUS = 8'hf0;

   // Power-on values
   localparam logic [7:0] PROTECT_RST   = 8'h38;
   localparam logic [7:0] CONFIG_RST    = 8'h10;
   localparam logic [7:0] DRIVE_RST     = 8'h00;
   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] PROTECT_MASK  = 8'hbe;
   localparam logic [7:0] CONFIG_MASK   = 8'hdb;
   localparam logic [7:0] DRIVE_MASK    = 8'h60;

   localparam int BIT_PIN_LOCK   = 7;
   localparam int BIT_OTP_LOCK   = 7;
   localparam int BIT_LOCKDOWN   = 2;
   localparam int BIT_ECC_EN     = 4;
   localparam int BIT_QUAD       = 0;

   localparam int CLK_PERIOD_NS  = 50;
   localparam int ERASE_BUSY_NS  = 3000000;
   localparam int RESET_RECOV_NS = 1000000;
   localparam int ERASE_CYCLES   =
      (ERASE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYCLES   =
      (RESET_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_BYTES     = 3;

   typedef struct packed {
      logic [1:0] corr_status;
      logic       prog_fail;
      logic       erase_fail;
      logic       write_latch;
      logic       busy_flag;
   } snerf_status_t;

   // Byte event from the link domain
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } snerf_byte_t;

endpackage : snerf_pkg

// file: core/snerf_core.sv
// Purpose: Serial NAND erase, resets and feature registers behind SPI
// Assumes: SPI mode 0, MSB first, sck runs only inside chip-select frames
// Notes:   Array access is modelled by status inputs from the array side
//
// Overview of operation
// - Erase without a set write latch is ignored entirely.
// - Erase opcode takes 24-bit row address; one block per command.
// - After address capture, erase and verify run busy for erase time.
// - Soft reset aborts any program, erase or read and goes idle.
// - Accepted power-on reset restores volatile defaults; lockdown bit and, under lockdown, protection are kept.
// - During reset recovery every command is rejected.
// - Get and set features take a one-byte feature address.
// - Written feature values persist; soft reset leaves them.
// - Status holds ECC status, program fail, erase fail, latch, busy.
// - Protection, config, drive writable; status registers read-only.
// - Pin lock set with write-protect low refuses protection writes.
// - Quad commands run only while quad enable is set; default zero.
// - One-time area lock survives power loss; others are volatile.
// - Internal ECC enable defaults to one at power-up.
// - ECC status clears on reset and read start, updates on read end.
// - ECC status is meaningless while internal ECC is disabled.
// - After power-on reset ECC status reflects page zero of block zero.
// - Busy reads one during execute, read, erase or reset.
// - Erase fail set on failure or locked block; cleared at erase start.
// - Write latch set by write enable, cleared by write disable.
// - ECC codes: 00 none, 01 corrected with count, 10 uncorrectable.
`timescale 1ns/10ps
module snerf_core #(
   parameter int ERASE_CYC = snerf_pkg::ERASE_CYCLES,
   parameter int RECOV_CYC = snerf_pkg::RECOV_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        sck_i,
   input  wire logic        cs_n_i,
   input  wire logic        mosi_i,
   input  wire logic        wp_n_i,
   input  wire logic        otp_lock_nv_i,
   input  wire logic        blk_locked_i,
   input  wire logic        erase_ok_i,
   input  wire logic        read_start_i,
   input  wire logic        read_done_i,
   input  wire logic [3:0]  read_ecc_i,
   input  wire logic        array_busy_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   output logic             erase_go_o,
   output logic [23:0]      erase_row_o,
   output logic             abort_o,
   output logic             quad_ok_o,
   output logic             ecc_en_o,
   output logic [1:0]       drive_sel_o
);

   // ---- Link domain: shift in bytes, shift out answer ----
   logic [2:0] bit_cnt_q;
   logic [6:0] sh_q;
   logic       first_q;
   logic       tog_q;
   snerf_pkg::snerf_byte_t byte_q;
   logic [7:0] tx_q;
   logic [39:0] tx_word_q;
   logic [39:0] tx_s1_q;
   logic [39:0] tx_s2_q;
   logic [7:0] tx_pick;

   always_ff @(posedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         bit_cnt_q <= 3'h0;
         first_q   <= 1'b1;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         sh_q      <= {sh_q[5:0], mosi_i};
         if (bit_cnt_q == 3'h7)
            first_q <= 1'b0;
      end
   end

   always_ff @(posedge sck_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tog_q  <= 1'b0;
         byte_q <= '0;
      end
      else if (!cs_n_i && bit_cnt_q == 3'h7)
      begin
         tog_q  <= ~tog_q;
         byte_q <= '{first: first_q, data: {sh_q, mosi_i}};
      end
   end

   // Register values are quasi-static; a snapshot per byte is enough
   always_ff @(posedge sck_i)
   begin
      tx_s1_q <= tx_word_q;
      tx_s2_q <= tx_s1_q;
   end

   // Answer picked by the byte just taken, so the MSB is out at once
   always_comb
   begin
      unique case (byte_q.data)
         snerf_pkg::FA_PROTECT:    tx_pick = tx_s2_q[39:32];
         snerf_pkg::FA_CONFIG:     tx_pick = tx_s2_q[31:24];
         snerf_pkg::FA_STATUS:     tx_pick = tx_s2_q[23:16];
         snerf_pkg::FA_DRIVE:      tx_pick = tx_s2_q[15:8];
         snerf_pkg::FA_EXT_STATUS: tx_pick = tx_s2_q[7:0];
         default:                  tx_pick = 8'h00;
      endcase
   end

   always_ff @(negedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         tx_q <= 8'h00;
      else if (bit_cnt_q == 3'h0)
         tx_q <= tx_pick;
      else
         tx_q <= {tx_q[6:0], 1'b0};
   end

   always_ff @(negedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         miso_o <= 1'b0;
      else
         miso_o <= (bit_cnt_q == 3'h0) ? tx_pick[7] : tx_q[6];
   end

   // ---- Crossings into the system clock ----
   logic [2:0] tog_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] wp_s_q;
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tog_s_q <= 3'h0;
         cs_s_q  <= 2'h3;
         wp_s_q  <= 2'h3;
      end
      else
      begin
         tog_s_q <= {tog_s_q[1:0], tog_q};
         cs_s_q  <= {cs_s_q[0], cs_n_i};
         wp_s_q  <= {wp_s_q[0], wp_n_i};
      end
   end
   wire byte_ev  = tog_s_q[2] ^ tog_s_q[1];
   wire cs_hi    = cs_s_q[1];
   wire wp_low   = ~wp_s_q[1];

   // ---- Command decoder ----
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_ADDR = 6'h02, S_FADR = 6'h04,
      S_DATA = 6'h08, S_READ = 6'h10, S_SKIP = 6'h20
   } snerf_state_t;
   snerf_state_t st_q;
   logic [7:0]  op_q;
   logic [7:0]  fadr_q;
   logic [1:0]  acnt_q;
   logic [23:0] row_q;
   logic        por_armed_q;
   logic        cs_hi_q;
   logic [31:0] erase_cnt_q;
   logic [31:0] recov_cnt_q;
   logic        erasing_q;
   logic        recov_q;
   logic        cmd_ok;
   logic        erase_fire;
   logic        soft_rst;
   logic        por_fire;
   logic        set_fire;
   logic [7:0]  set_val;

   always_ff @(posedge clock_i or posedge rst_i)
      if (rst_i)
         cs_hi_q <= 1'b1;
      else
         cs_hi_q <= cs_hi;
   wire frame_end = cs_hi & ~cs_hi_q;

   assign cmd_ok = ~recov_q & byte_ev;
   wire is_op = cmd_ok & byte_q.first;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q   <= S_IDLE;
         op_q   <= 8'h00;
         fadr_q <= 8'h00;
         acnt_q <= 2'h0;
         row_q  <= 24'h000000;
      end
      else if (frame_end || por_fire)
         st_q <= S_IDLE;
      else if (is_op)
      begin
         op_q   <= byte_q.data;
         acnt_q <= 2'h0;
         unique case (byte_q.data)
            snerf_pkg::OP_ERASE:    st_q <= S_ADDR;
            snerf_pkg::OP_GET_FEAT: st_q <= S_FADR;
            snerf_pkg::OP_SET_FEAT: st_q <= S_FADR;
            default:                st_q <= S_SKIP;
         endcase
      end
      else if (cmd_ok)
      begin
         unique case (st_q)
            S_ADDR:
            begin
               row_q  <= {row_q[15:0], byte_q.data};
               acnt_q <= acnt_q + 2'h1;
               if (acnt_q == 2'(snerf_pkg::ADDR_BYTES - 1))
                  st_q <= S_SKIP;
            end
            S_FADR:
            begin
               fadr_q <= byte_q.data;
               st_q   <= (op_q == snerf_pkg::OP_SET_FEAT) ? S_DATA : S_READ;
            end
            S_DATA:  st_q <= S_SKIP;
            S_READ:  st_q <= S_READ;
            S_SKIP:  st_q <= S_SKIP;
            S_IDLE:  st_q <= S_IDLE;
         endcase
      end
   end

   wire addr_done = cmd_ok & ~byte_q.first & (st_q == S_ADDR) &
                    (acnt_q == 2'(snerf_pkg::ADDR_BYTES - 1));
   assign erase_fire = addr_done & ~erasing_q;
   assign set_fire   = cmd_ok & ~byte_q.first & (st_q == S_DATA);
   assign set_val    = byte_q.data;
   assign soft_rst   = is_op & (byte_q.data == snerf_pkg::OP_SOFT_RST);
   assign por_fire   = is_op & por_armed_q &
                       (byte_q.data == snerf_pkg::OP_POR);

   // Arm only from a frame holding the enable opcode alone
   always_ff @(posedge clock_i or posedge rst_i)
      if (rst_i)
         por_armed_q <= 1'b0;
      else if (is_op)
         por_armed_q <= (byte_q.data == snerf_pkg::OP_EN_POR);
      else if (cmd_ok)
         por_armed_q <= 1'b0;

   // ---- Erase and recovery timers ----
   snerf_pkg::snerf_status_t stat_q;
   wire erase_start = erase_fire & stat_q.write_latch & ~blk_locked_i;
   wire erase_end   = erasing_q && erase_cnt_q == 32'(ERASE_CYC - 1);

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         erasing_q   <= 1'b0;
         erase_cnt_q <= 32'h0;
      end
      else if (soft_rst || por_fire)
         erasing_q   <= 1'b0;
      else if (erase_start)
      begin
         erasing_q   <= 1'b1;
         erase_cnt_q <= 32'h0;
      end
      else if (erasing_q)
      begin
         erase_cnt_q <= erase_cnt_q + 32'h1;
         if (erase_end)
            erasing_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         recov_q     <= 1'b0;
         recov_cnt_q <= 32'h0;
      end
      else if (por_fire)
      begin
         recov_q     <= 1'b1;
         recov_cnt_q <= 32'h0;
      end
      else if (recov_q)
      begin
         recov_cnt_q <= recov_cnt_q + 32'h1;
         if (recov_cnt_q == 32'(RECOV_CYC - 1))
            recov_q <= 1'b0;
      end
   end

   // ---- Feature registers ----
   logic [7:0] prot_q;
   logic [7:0] cfg_q;
   logic [7:0] drv_q;
   logic [1:0] ecc_cnt_q;
   logic       ecc_sync_q;
   wire prot_lock = prot_q[snerf_pkg::BIT_PIN_LOCK] & wp_low;
   wire lockdown  = cfg_q[snerf_pkg::BIT_LOCKDOWN];

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prot_q <= snerf_pkg::PROTECT_RST;
         cfg_q  <= snerf_pkg::CONFIG_RST;
         drv_q  <= snerf_pkg::DRIVE_RST;
      end
      else if (por_fire)
      begin
         prot_q <= lockdown ? prot_q : snerf_pkg::PROTECT_RST;
         cfg_q  <= snerf_pkg::CONFIG_RST |
                   {8'(lockdown) << snerf_pkg::BIT_LOCKDOWN};
         drv_q  <= snerf_pkg::DRIVE_RST;
      end
      else if (set_fire)
      begin
         if (fadr_q == snerf_pkg::FA_PROTECT && !prot_lock && !lockdown)
            prot_q <= set_val & snerf_pkg::PROTECT_MASK;
         if (fadr_q == snerf_pkg::FA_CONFIG)
            cfg_q  <= (set_val & snerf_pkg::CONFIG_MASK) |
                      {8'(lockdown | set_val[snerf_pkg::BIT_LOCKDOWN])
                       << snerf_pkg::BIT_LOCKDOWN};
         if (fadr_q == snerf_pkg::FA_DRIVE)
            drv_q  <= set_val & snerf_pkg::DRIVE_MASK;
      end
   end

   // ---- Status register ----
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stat_q     <= '0;
         ecc_cnt_q  <= 2'h0;
         ecc_sync_q <= 1'b1;
      end
      else
      begin
         // Write latch: set by enable, dropped by erase or disable
         if (is_op && byte_q.data == snerf_pkg::OP_WR_ENABLE)
            stat_q.write_latch <= 1'b1;
         else if (is_op && byte_q.data == snerf_pkg::OP_WR_DISABLE)
            stat_q.write_latch <= 1'b0;
         else if (erase_fire || erase_end || por_fire)
            stat_q.write_latch <= 1'b0;
         if (erase_fire && stat_q.write_latch)
            stat_q.erase_fail <= blk_locked_i;
         else if (erase_end)
            stat_q.erase_fail <= ~erase_ok_i;
         else if (soft_rst || por_fire)
            stat_q.erase_fail <= 1'b0;
         if (soft_rst || por_fire)
            stat_q.prog_fail <= 1'b0;
         stat_q.busy_flag <= erasing_q | recov_q | array_busy_i;
         ecc_sync_q <= por_fire;
         if (soft_rst || read_start_i)
         begin
            stat_q.corr_status <= 2'h0;
            ecc_cnt_q <= 2'h0;
         end
         else if (read_done_i || ecc_sync_q)
         begin
            // Page zero result is delivered after power-on reset
            stat_q.corr_status <= read_ecc_i[3:2];
            ecc_cnt_q <= read_ecc_i[1:0];
         end
      end
   end

   // ---- Read-back words and user outputs ----
   // All five answers travel together; the link side picks one
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         tx_word_q <= 40'h0000000000;
      else
         tx_word_q <= {prot_q,
                       cfg_q | {8'(otp_lock_nv_i) << snerf_pkg::BIT_OTP_LOCK},
                       {2'h0, stat_q}, drv_q,
                       {2'h0, ecc_cnt_q, 4'h0}};
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         erase_go_o  <= 1'b0;
         erase_row_o <= 24'h000000;
         abort_o     <= 1'b0;
         quad_ok_o   <= 1'b0;
         ecc_en_o    <= 1'b1;
         drive_sel_o <= 2'h0;
         miso_oe_o   <= 1'b0;
      end
      else
      begin
         erase_go_o  <= erase_start;
         if (erase_start)
            erase_row_o <= {row_q[15:0], byte_q.data};
         abort_o     <= soft_rst | por_fire;
         quad_ok_o   <= cfg_q[snerf_pkg::BIT_QUAD];
         ecc_en_o    <= cfg_q[snerf_pkg::BIT_ECC_EN];
         drive_sel_o <= drv_q[6:5];
         miso_oe_o   <= (st_q == S_READ) & ~cs_hi;
      end
   end

   chk_erase_latch_gate: assert property (@(posedge clock_i) disable iff (rst_i)
      erase_go_o |-> $past(stat_q.write_latch))
      else $error("erase without write latch");
   chk_recov_reject: assert property (@(posedge clock_i) disable iff (rst_i)
      recov_q |-> !erase_start && !set_fire)
      else $error("command taken in recovery");
   chk_busy_erase: assert property (@(posedge clock_i) disable iff (rst_i)
      erase_start |=> ##1 stat_q.busy_flag)
      else $error("busy not raised by erase");
   chk_soft_abort: assert property (@(posedge clock_i) disable iff (rst_i)
      soft_rst |=> !erasing_q ##0 abort_o)
      else $error("soft reset did not abort");
   chk_lockdown_hold: assert property (@(posedge clock_i) disable iff (rst_i)
      lockdown |=> prot_q == $past(prot_q))
      else $error("protection changed under lockdown");
   chk_pin_lock: assert property (@(posedge clock_i) disable iff (rst_i)
      prot_lock && !por_fire |=> prot_q == $past(prot_q))
      else $error("protection written while pin locked");
   chk_latch_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      erase_fire && !is_op |=> !stat_q.write_latch)
      else $error("latch kept after erase");
   chk_ecc_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      read_start_i |=> stat_q.corr_status == 2'h0)
      else $error("ecc status not cleared");

endmodule : snerf_core

// file: tb/snerf_host_model.sv
// Purpose: Host SPI controller issuing framed flash commands
// Assumes: Mode 0, MSB first, link clock 30 ns, sck only inside frames
// Notes:   Released mosi shows the inverse of its last bit
`timescale 1ns/10ps
module snerf_host_model (
   input  wire logic miso_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   logic lclk;
   logic run;

   initial
   begin
      lclk = 1'b0;
      forever #15 lclk = ~lclk;
   end

   initial
   begin
      run    = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // Gated so sck stands low between bytes and frames
   assign sck_o = lclk & run;

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge lclk);
         mosi_o <= tx[i];
         run    <= 1'b1;
         @(posedge lclk);
         rx[i] = miso_i;
      end
      @(negedge lclk);
      run    <= 1'b0;
      mosi_o <= ~tx[0];
      // Gap lets the answer byte get ready
      repeat (10) @(posedge lclk);
   endtask : xfer

   task automatic frame(input int n, input logic [7:0] b0, b1, b2, b3,
                        output logic [7:0] rx);
      logic [7:0] bytes [4];
      bytes = '{b0, b1, b2, b3};
      @(negedge lclk);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge lclk);
      for (int k = 0; k < n; k++)
         xfer(bytes[k], rx);
      @(negedge lclk);
      cs_n_o <= 1'b1;
      repeat (10) @(posedge lclk);
   endtask : frame
endmodule : snerf_host_model

// file: tb/serial_nand_erase_reset_features_tb_top.sv
// Purpose: Self-checking bench for the serial NAND command core
// Assumes: Shortened erase and recovery counts
// Notes:   Array side driven directly by the bench
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; \
   if ((got) !== (ex)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", nm, (ex), (got)); end end
module serial_nand_erase_reset_features_tb_top;
   localparam int ERASE_CYC = 200;
   localparam int RECOV_CYC = 40;
   logic        clock_i, rst_i, sck, cs_n, mosi, miso, miso_oe;
   logic        miso_last = 1'b0;
   logic        wp_n, otp_nv, blk_locked, erase_ok, rd_start, rd_done;
   logic        erase_go, abort, quad_ok, ecc_en;
   logic [3:0]  rd_ecc;
   logic [1:0]  drive_sel;
   logic [23:0] erase_row;
   logic [7:0]  v;
   wire logic   miso_w = miso_oe ? miso : ~miso_last;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          go_cnt = 0;
   int          abort_cnt = 0;

   snerf_core #(.ERASE_CYC(ERASE_CYC), .RECOV_CYC(RECOV_CYC)) i_snerf_core (
      .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
      .mosi_i(mosi), .wp_n_i(wp_n), .otp_lock_nv_i(otp_nv),
      .blk_locked_i(blk_locked), .erase_ok_i(erase_ok),
      .read_start_i(rd_start), .read_done_i(rd_done), .read_ecc_i(rd_ecc),
      .array_busy_i(1'b0), .miso_o(miso), .miso_oe_o(miso_oe),
      .erase_go_o(erase_go), .erase_row_o(erase_row), .abort_o(abort),
      .quad_ok_o(quad_ok), .ecc_en_o(ecc_en), .drive_sel_o(drive_sel));

   snerf_host_model i_snerf_host_model (
      .miso_i(miso_w), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   always @(posedge clock_i)
   begin
      if (miso_oe === 1'b1) miso_last <= miso;
      if (erase_go === 1'b1) go_cnt <= go_cnt + 1;
      if (abort === 1'b1) abort_cnt <= abort_cnt + 1;
   end

   task automatic conclude();
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic get(input logic [7:0] fa, output logic [7:0] d);
      i_snerf_host_model.frame(3, snerf_pkg::OP_GET_FEAT, fa, 8'h00, 8'h00, d);
   endtask : get

   task automatic set(input logic [7:0] fa, input logic [7:0] d);
      logic [7:0] rx;
      i_snerf_host_model.frame(3, snerf_pkg::OP_SET_FEAT, fa, d, 8'h00, rx);
   endtask : set

   task automatic cmd(input logic [7:0] op);
      logic [7:0] rx;
      i_snerf_host_model.frame(1, op, 8'h00, 8'h00, 8'h00, rx);
   endtask : cmd

   task automatic erase(input logic [23:0] row);
      logic [7:0] rx;
      i_snerf_host_model.frame(4, snerf_pkg::OP_ERASE, row[23:16], row[15:8],
                               row[7:0], rx);
   endtask : erase

   task automatic feat(input logic [7:0] fa, input logic [7:0] ex,
                       input string nm);
      logic [7:0] d;
      get(fa, d);
      `CHK(nm, ex, d)
   endtask : feat

   task automatic t_defaults();
      feat(snerf_pkg::FA_PROTECT, 8'h38, "protect");
      feat(snerf_pkg::FA_CONFIG, 8'h90, "config");
      feat(snerf_pkg::FA_STATUS, 8'h00, "status");
      feat(snerf_pkg::FA_DRIVE, 8'h00, "drive");
      `CHK("ecc_en", 1'b1, ecc_en)
      `CHK("quad_ok", 1'b0, quad_ok)
   endtask : t_defaults

   task automatic t_erase_gate();
      erase(24'h000040);
      `CHK("go none", 0, go_cnt)
      feat(snerf_pkg::FA_STATUS, 8'h00, "no latch");
      cmd(snerf_pkg::OP_WR_ENABLE);
      feat(snerf_pkg::FA_STATUS, 8'h02, "latch");
      @(posedge clock_i) blk_locked <= 1'b1;
      erase(24'h000080);
      `CHK("go locked", 0, go_cnt)
      feat(snerf_pkg::FA_STATUS, 8'h04, "locked");
      @(posedge clock_i) blk_locked <= 1'b0;
      cmd(snerf_pkg::OP_WR_ENABLE);
      cmd(snerf_pkg::OP_WR_DISABLE);
      feat(snerf_pkg::FA_STATUS, 8'h04, "disable");
   endtask : t_erase_gate

   task automatic t_erase_run();
      cmd(snerf_pkg::OP_WR_ENABLE);
      erase(24'h123456);
      `CHK("go one", 1, go_cnt)
      `CHK("row", 24'h123456, erase_row)
      feat(snerf_pkg::FA_STATUS, 8'h01, "busy");
      repeat (ERASE_CYC / 2) @(posedge clock_i);
      feat(snerf_pkg::FA_STATUS, 8'h01, "busy mid");
      v = 8'h01;
      for (int k = 0; k < 20 && v[0] !== 1'b0; k++)
         get(snerf_pkg::FA_STATUS, v);
      `CHK("done", 8'h00, v)
      @(posedge clock_i) erase_ok <= 1'b0;
      cmd(snerf_pkg::OP_WR_ENABLE);
      erase(24'h000100);
      repeat (ERASE_CYC + 10) @(posedge clock_i);
      feat(snerf_pkg::FA_STATUS, 8'h04, "fail");
      @(posedge clock_i) erase_ok <= 1'b1;
      cmd(snerf_pkg::OP_WR_ENABLE);
      erase(24'h000140);
      cmd(snerf_pkg::OP_SOFT_RST);
      `CHK("abort", 1, abort_cnt)
      feat(snerf_pkg::FA_STATUS, 8'h00, "aborted");
      `CHK("go total", 3, go_cnt)
   endtask : t_erase_run

   task automatic t_features();
      @(posedge clock_i) otp_nv <= 1'b0;
      set(snerf_pkg::FA_CONFIG, 8'h01);
      set(snerf_pkg::FA_DRIVE, 8'h40);
      set(snerf_pkg::FA_STATUS, 8'hff);
      `CHK("quad on", 1'b1, quad_ok)
      `CHK("ecc off", 1'b0, ecc_en)
      `CHK("drive sel", 2'b10, drive_sel)
      feat(snerf_pkg::FA_STATUS, 8'h00, "status ro");
      cmd(snerf_pkg::OP_SOFT_RST);
      `CHK("abort 2", 2, abort_cnt)
      feat(snerf_pkg::FA_CONFIG, 8'h01, "cfg keep");
      feat(snerf_pkg::FA_DRIVE, 8'h40, "drv keep");
   endtask : t_features

   task automatic t_protect();
      @(posedge clock_i) wp_n <= 1'b0;
      set(snerf_pkg::FA_PROTECT, 8'h80);
      set(snerf_pkg::FA_PROTECT, 8'h00);
      feat(snerf_pkg::FA_PROTECT, 8'h80, "pin lock");
      @(posedge clock_i) wp_n <= 1'b1;
      set(snerf_pkg::FA_PROTECT, 8'h38);
      feat(snerf_pkg::FA_PROTECT, 8'h38, "pin free");
      set(snerf_pkg::FA_CONFIG, 8'h15);
      set(snerf_pkg::FA_PROTECT, 8'h00);
      feat(snerf_pkg::FA_PROTECT, 8'h38, "lockdown");
   endtask : t_protect

   task automatic t_ecc();
      @(posedge clock_i) rd_ecc <= 4'b0111;
      rd_done <= 1'b1;
      @(posedge clock_i) rd_done <= 1'b0;
      feat(snerf_pkg::FA_STATUS, 8'h10, "corrected");
      feat(snerf_pkg::FA_EXT_STATUS, 8'h30, "count");
      @(posedge clock_i) rd_start <= 1'b1;
      @(posedge clock_i) rd_start <= 1'b0;
      feat(snerf_pkg::FA_STATUS, 8'h00, "rd start");
      @(posedge clock_i) rd_ecc <= 4'b1000;
      rd_done <= 1'b1;
      @(posedge clock_i) rd_done <= 1'b0;
      feat(snerf_pkg::FA_STATUS, 8'h20, "uncorr");
      cmd(snerf_pkg::OP_SOFT_RST);
      feat(snerf_pkg::FA_STATUS, 8'h00, "rst clr");
   endtask : t_ecc

   task automatic t_por();
      @(posedge clock_i) rd_ecc <= 4'b0100;
      cmd(snerf_pkg::OP_EN_POR);
      cmd(snerf_pkg::OP_POR);
      cmd(snerf_pkg::OP_WR_ENABLE);
      `CHK("abort por", 4, abort_cnt)
      repeat (RECOV_CYC + 10) @(posedge clock_i);
      feat(snerf_pkg::FA_STATUS, 8'h10, "por stat");
      feat(snerf_pkg::FA_CONFIG, 8'h14, "por cfg");
      feat(snerf_pkg::FA_DRIVE, 8'h00, "por drv");
      feat(snerf_pkg::FA_PROTECT, 8'h38, "por prot");
      `CHK("por quad", 1'b0, quad_ok)
      `CHK("por ecc", 1'b1, ecc_en)
   endtask : t_por

   initial
   begin
      rst_i      = 1'b1;
      wp_n       = 1'b1;
      otp_nv     = 1'b1;
      blk_locked = 1'b0;
      erase_ok   = 1'b1;
      rd_start   = 1'b0;
      rd_done    = 1'b0;
      rd_ecc     = 4'h0;
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      t_defaults();
      t_erase_gate();
      t_erase_run();
      t_features();
      t_protect();
      t_ecc();
      t_por();
      conclude();
   end

   initial
   begin
      #1000000;
      mismatches++;
      conclude();
   end
endmodule : serial_nand_erase_reset_features_tb_top
